// file: rtl/ivf_pkg.sv
/*
  constants of the local configuration bank: offsets, reset values,
  field positions and oscillator timing for the clock phase timers.
  assumes a single 100 MHz clock domain and 8-bit registers.
*/
package ivf_pkg;
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] IVF_OFS_SCL_HIGH = 8'h0B;
  localparam logic [7:0] IVF_OFS_SCL_LOW = 8'h0C;
  localparam logic [7:0] IVF_OFS_PIN_DATA = 8'h0D;
  localparam logic [7:0] IVF_OFS_PIN_CTRL = 8'h0E;
  localparam logic [7:0] IVF_OFS_VID_CFG = 8'h10;
  localparam logic [7:0] IVF_OFS_MATCH_TYPE = 8'h11;
  ////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] IVF_RST_SCL_HIGH = 8'h7F;
  localparam logic [7:0] IVF_RST_SCL_LOW = 8'h7F;
  localparam logic [3:0] IVF_RST_FWD_EN = 4'hF;
  localparam logic [3:0] IVF_RST_OUT_VAL = 4'h0;
  localparam logic [3:0] IVF_RST_DRIVE_EN = 4'h0;
  localparam logic [3:0] IVF_RST_SAMPLE_EN = 4'hF;
  localparam logic [7:0] IVF_RST_VID_CFG = 8'h00;
  localparam logic [5:0] IVF_RST_MATCH_TYPE = 6'h00;
  ////////////////////////////////////////////////////////////////////////
  localparam int IVF_BIT_ANY_LONG = 4;
  localparam int IVF_BIT_MATCH_EN = 3;
  localparam int IVF_BIT_YUV_EN = 2;
  localparam int IVF_BIT_FV_INV = 1;
  localparam int IVF_BIT_LV_INV = 0;
  localparam logic [7:0] IVF_VID_CFG_MASK = 8'h1F;
  localparam logic [5:0] IVF_DT_YUV_A = 6'h19;
  localparam logic [5:0] IVF_DT_YUV_B = 6'h1D;
  localparam logic [5:0] IVF_DT_YUV_C = 6'h1F;
  ////////////////////////////////////////////////////////////////////////
  // oscillator ticks are derived from the 100 MHz clock by a phase
  // accumulator; one tick is one 38.0952 ns oscillator period
  localparam real IVF_OSC_PERIOD_NS = 38.0952;
  localparam real IVF_CLK_PERIOD_NS = 10.0;
  localparam logic [16:0] IVF_ACC_WRAP = 17'(int'(IVF_OSC_PERIOD_NS * 1000.0));
  localparam logic [16:0] IVF_ACC_STEP = 17'(int'(IVF_CLK_PERIOD_NS * 1000.0));
  localparam logic [8:0] IVF_EXTRA_TICKS = 9'h005;
endpackage

// file: rtl/ivf_regs.sv
/*
  local configuration bank: clock phase timing for the local two-wire
  bus, local pin sourcing and drive, parallel video type filter.
  assumes register port and video inputs are on ref_clk; pin_in is
  asynchronous and is synchronised here.
*/
// Behaviour
// - scl high phase timed by 8-bit count
// - high phase lasts (count + 5) oscillator periods
// - high count resets to 0x7F
// - low phase (count + 5) periods, reset 0x7F
// - target setup uses low count before release
// - forward-enabled pins follow remote values
// - local value driven if unforwarded and enabled
// - bits 7:4 enable pin drivers, reset off
// - bits 3:0 enable pin sampling, reset on
// - any-long bit passes all long types
// - match enable passes equal data type
// - match value write blocked while matching
// - yuv bit passes 0x19/0x1D/0x1F at high rate
// - bit 1 inverts frame valid
// - bit 0 inverts line valid
// - match needs long type, any rate mode
module ivf_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  // local bus clock, controller and target roles
  input wire logic scl_run,
  output logic scl_o,
  output logic scl_oe,
  input wire logic tgt_setup_start,
  output logic tgt_scl_release,
  // pins
  input wire logic [3:0] remote_pin_value,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_o,
  output logic [3:0] pin_oe,
  output logic [3:0] pin_sampled,
  // parallel video filter
  input wire logic high_rate_video_mode,
  input wire logic pkt_valid,
  input wire logic [5:0] pkt_type,
  input wire logic frame_valid_in,
  input wire logic line_valid_in,
  output logic pkt_pass,
  output logic frame_valid_out,
  output logic line_valid_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import ivf_pkg::*;

  logic [7:0] scl_high_cnt_r;
  logic [7:0] scl_low_cnt_r;
  logic [3:0] remote_pin_forward_en_r;
  logic [3:0] pin_output_value_r;
  logic [3:0] pin_drive_en_r;
  logic [3:0] pin_sample_en_r;
  logic [7:0] vid_cfg_r;
  logic [5:0] match_type_value_r;
  logic pass_any_long_type;
  logic type_match_en;
  logic pass_yuv10_types;
  logic frame_valid_invert;
  logic line_valid_invert;

  assign pass_any_long_type = vid_cfg_r[IVF_BIT_ANY_LONG];
  assign type_match_en = vid_cfg_r[IVF_BIT_MATCH_EN];
  assign pass_yuv10_types = vid_cfg_r[IVF_BIT_YUV_EN];
  assign frame_valid_invert = vid_cfg_r[IVF_BIT_FV_INV];
  assign line_valid_invert = vid_cfg_r[IVF_BIT_LV_INV];

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      scl_high_cnt_r <= IVF_RST_SCL_HIGH;
      scl_low_cnt_r <= IVF_RST_SCL_LOW;
      remote_pin_forward_en_r <= IVF_RST_FWD_EN;
      pin_output_value_r <= IVF_RST_OUT_VAL;
      pin_drive_en_r <= IVF_RST_DRIVE_EN;
      pin_sample_en_r <= IVF_RST_SAMPLE_EN;
      vid_cfg_r <= IVF_RST_VID_CFG;
    end else if (reg_wr_en) begin
      case (reg_addr)
        IVF_OFS_SCL_HIGH: scl_high_cnt_r <= reg_wr_data;
        IVF_OFS_SCL_LOW: scl_low_cnt_r <= reg_wr_data;
        IVF_OFS_PIN_DATA: begin
          remote_pin_forward_en_r <= reg_wr_data[7:4];
          pin_output_value_r <= reg_wr_data[3:0];
        end
        IVF_OFS_PIN_CTRL: begin
          pin_drive_en_r <= reg_wr_data[7:4];
          pin_sample_en_r <= reg_wr_data[3:0];
        end
        // reserved bits are not stored and read back as zero
        IVF_OFS_VID_CFG: vid_cfg_r <= reg_wr_data & IVF_VID_CFG_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      match_type_value_r <= IVF_RST_MATCH_TYPE;
    end else if (reg_wr_en && reg_addr == IVF_OFS_MATCH_TYPE && !type_match_en) begin
      match_type_value_r <= reg_wr_data[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered read, unmapped offsets read zero
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rd_data <= 8'h00;
    end else begin
      case (reg_addr)
        IVF_OFS_SCL_HIGH: reg_rd_data <= scl_high_cnt_r;
        IVF_OFS_SCL_LOW: reg_rd_data <= scl_low_cnt_r;
        IVF_OFS_PIN_DATA: reg_rd_data <= {remote_pin_forward_en_r, pin_output_value_r};
        IVF_OFS_PIN_CTRL: reg_rd_data <= {pin_drive_en_r, pin_sample_en_r};
        IVF_OFS_VID_CFG: reg_rd_data <= vid_cfg_r;
        IVF_OFS_MATCH_TYPE: reg_rd_data <= {2'b00, match_type_value_r};
        default: reg_rd_data <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator tick from a phase accumulator
  logic [16:0] osc_acc_r;
  logic osc_tick;
  assign osc_tick = (osc_acc_r + IVF_ACC_STEP) >= IVF_ACC_WRAP;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      osc_acc_r <= 17'h00000;
    end else if (osc_tick) begin
      osc_acc_r <= osc_acc_r + IVF_ACC_STEP - IVF_ACC_WRAP;
    end else begin
      osc_acc_r <= osc_acc_r + IVF_ACC_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // controller clock generator: high phase first, then low phase
  logic scl_high_r;
  logic [8:0] scl_tick_cnt_r;
  logic [8:0] scl_phase_last;
  logic scl_phase_done;
  assign scl_phase_last = (scl_high_r ? {1'b0, scl_high_cnt_r} : {1'b0, scl_low_cnt_r})
    + IVF_EXTRA_TICKS - 9'h001;
  assign scl_phase_done = scl_run && osc_tick && scl_tick_cnt_r == scl_phase_last;

  always_ff @(posedge ref_clk) begin
    if (!rst_b || !scl_run) begin
      scl_high_r <= 1'b1;
      scl_tick_cnt_r <= 9'h000;
    end else if (scl_phase_done) begin
      scl_high_r <= !scl_high_r;
      scl_tick_cnt_r <= 9'h000;
    end else if (osc_tick) begin
      scl_tick_cnt_r <= scl_tick_cnt_r + 9'h001;
    end
  end

  // clock cycles spent in the current phase, kept apart from the tick count
  // so that the phase length checks do not repeat the counter they guard
  logic [10:0] scl_phase_cyc_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_b || !scl_run || scl_phase_done) begin
      scl_phase_cyc_r <= 11'h000;
    end else begin
      scl_phase_cyc_r <= scl_phase_cyc_r + 11'h001;
    end
  end

  // open drain: only the low level is driven
  assign scl_o = 1'b0;
  assign scl_oe = scl_run && !scl_high_r;

  ////////////////////////////////////////////////////////////////////////
  // target data setup before a held clock is released
  logic tgt_busy_r;
  logic [8:0] tgt_tick_cnt_r;
  logic tgt_done;
  assign tgt_done = tgt_busy_r && osc_tick
    && tgt_tick_cnt_r == {1'b0, scl_low_cnt_r} + IVF_EXTRA_TICKS - 9'h001;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tgt_busy_r <= 1'b0;
      tgt_tick_cnt_r <= 9'h000;
      tgt_scl_release <= 1'b0;
    end else begin
      tgt_scl_release <= tgt_done;
      if (tgt_setup_start && !tgt_busy_r) begin
        tgt_busy_r <= 1'b1;
        tgt_tick_cnt_r <= 9'h000;
      end else if (tgt_done) begin
        tgt_busy_r <= 1'b0;
      end else if (tgt_busy_r && osc_tick) begin
        tgt_tick_cnt_r <= tgt_tick_cnt_r + 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins: source select, drivers and synchronised sampling
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end else begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  generate
    for (genvar i = 0; i < 4; i++) begin : g_pin
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          pin_o[i] <= 1'b0;
          pin_oe[i] <= 1'b0;
          pin_sampled[i] <= 1'b0;
        end else begin
          pin_o[i] <= remote_pin_forward_en_r[i] ? remote_pin_value[i]
            : pin_output_value_r[i];
          pin_oe[i] <= remote_pin_forward_en_r[i] || pin_drive_en_r[i];
          pin_sampled[i] <= pin_sample_en_r[i] && pin_sync_r[i];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // parallel video filter
  logic pkt_long;
  logic pkt_yuv10;
  logic pass_nxt;
  assign pkt_long = pkt_type[5] || pkt_type[4];
  assign pkt_yuv10 = pkt_type == IVF_DT_YUV_A || pkt_type == IVF_DT_YUV_B
    || pkt_type == IVF_DT_YUV_C;
  assign pass_nxt = pkt_valid && ((pkt_long && pass_any_long_type)
    || (pkt_long && type_match_en && pkt_type == match_type_value_r)
    || (pass_yuv10_types && high_rate_video_mode && pkt_yuv10));

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pkt_pass <= 1'b0;
      frame_valid_out <= 1'b0;
      line_valid_out <= 1'b0;
    end else begin
      pkt_pass <= pass_nxt;
      frame_valid_out <= frame_valid_in ^ frame_valid_invert;
      line_valid_out <= line_valid_in ^ line_valid_invert;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  scl_reset_vals_a: assert property (@(posedge ref_clk)
    !rst_b |=> scl_high_cnt_r == 8'h7F && scl_low_cnt_r == 8'h7F)
    else $error("clock counts not 0x7F after reset");

  high_phase_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (scl_phase_done && scl_high_r)
    |-> scl_phase_cyc_r + 11'h003 >= 11'h003 * ({3'h0, scl_high_cnt_r} + 11'h005)
    && scl_phase_cyc_r < 11'h004 * ({3'h0, scl_high_cnt_r} + 11'h005))
    else $error("high phase ended at wrong tick count");

  low_phase_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (scl_phase_done && !scl_high_r)
    |-> scl_phase_cyc_r + 11'h003 >= 11'h003 * ({3'h0, scl_low_cnt_r} + 11'h005)
    && scl_phase_cyc_r < 11'h004 * ({3'h0, scl_low_cnt_r} + 11'h005))
    else $error("low phase ended at wrong tick count");

  tgt_release_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tgt_scl_release |-> $past(tgt_tick_cnt_r) == {1'b0, scl_low_cnt_r} + 9'h004)
    else $error("target released clock early or late");

  pin_source_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    remote_pin_forward_en_r[0] |=> pin_oe[0] && pin_o[0] == $past(remote_pin_value[0]))
    else $error("forwarded pin does not follow remote value");

  pin_local_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!remote_pin_forward_en_r[1] && pin_drive_en_r[1])
    |=> pin_o[1] == $past(pin_output_value_r[1]))
    else $error("local value not driven");

  pin_drive_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!remote_pin_forward_en_r[2] && !pin_drive_en_r[2]) |=> !pin_oe[2])
    else $error("pin driven while disabled");

  pin_sample_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !pin_sample_en_r[3] |=> !pin_sampled[3])
    else $error("pin sampled while disabled");

  match_block_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_wr_en && reg_addr == IVF_OFS_MATCH_TYPE && type_match_en) |=> $stable(match_type_value_r))
    else $error("match value changed while matching");

  any_long_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (pkt_valid && pkt_long && pass_any_long_type) |=> pkt_pass)
    else $error("long type not passed");

  short_block_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (pkt_valid && !pkt_long && !(pass_yuv10_types && high_rate_video_mode)) |=> !pkt_pass)
    else $error("short type passed");

  yuv_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (pkt_valid && pkt_type == 6'h1D && pass_yuv10_types && high_rate_video_mode) |=> pkt_pass)
    else $error("yuv type not passed");

  valid_invert_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ##1 frame_valid_out == ($past(frame_valid_in) ^ $past(frame_valid_invert))
    && line_valid_out == ($past(line_valid_in) ^ $past(line_valid_invert)))
    else $error("valid polarity wrong");
endmodule

// file: sim/ivf_far_side.sv
/*
  far-side model: resolves the four pin wires and the local clock wire.
  assumes pins not driven by the device are driven by ext_val/ext_en.
*/
module ivf_far_side (
  // clock
  input wire logic ref_clk,
  // device side
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe,
  input wire logic scl_o,
  input wire logic scl_oe,
  // external pin drivers
  input wire logic [3:0] ext_val,
  input wire logic [3:0] ext_en,
  // resolved wires
  output logic [3:0] pin_level,
  output logic scl_level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] float_r = 4'h5;
  // an undriven pin wanders every cycle instead of keeping a level
  always @(posedge ref_clk) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_level[i] = pin_oe[i] ? pin_o[i] : (ext_en[i] ? ext_val[i] : float_r[i]);
    end
  end
  // clock wire has a pull-up; the device only pulls it down
  assign scl_level = scl_oe ? scl_o : 1'b1;
endmodule

// file: sim/ivf_regs_tb_top.sv
/*
  testbench of the local configuration bank: register table, pins,
  video filter, clock phase timing and target setup time.
  assumes ivf_far_side resolves the pin and clock wires.
*/
module ivf_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ivf_pkg::*;
  typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} ivf_row_t;
  localparam ivf_row_t ROWS [14] = '{
    '{8'h0B, 1'b0, 8'h00, 8'h7F}, '{8'h0C, 1'b0, 8'h00, 8'h7F}, '{8'h0D, 1'b0, 8'h00, 8'hF0},
    '{8'h0E, 1'b0, 8'h00, 8'h0F}, '{8'h10, 1'b0, 8'h00, 8'h00}, '{8'h11, 1'b0, 8'h00, 8'h00},
    '{8'h0F, 1'b0, 8'h00, 8'h00}, '{8'h12, 1'b0, 8'h00, 8'h00}, '{8'h0B, 1'b1, 8'hA5, 8'hA5},
    '{8'h0C, 1'b1, 8'h3C, 8'h3C}, '{8'h10, 1'b1, 8'hFF, 8'h1F}, '{8'h11, 1'b1, 8'h2A, 8'h00},
    '{8'h10, 1'b1, 8'h00, 8'h00}, '{8'h11, 1'b1, 8'hFF, 8'h3F}};
  localparam logic [7:0] CFGS [4] = '{8'h10, 8'h08, 8'h04, 8'h00};
  localparam logic [5:0] TYPES [6] = '{6'h2A, 6'h11, 6'h19, 6'h1D, 6'h1F, 6'h05};
  logic ref_clk, rst_b, reg_wr_en, scl_run, scl_o, scl_oe, tgt_setup_start, tgt_scl_release;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, v;
  logic [3:0] remote_pin_value, pin_level, pin_o, pin_oe, pin_sampled, ext_val, ext_en;
  logic high_rate_video_mode, pkt_valid, pkt_pass, frame_valid_in, line_valid_in;
  logic frame_valid_out, line_valid_out, scl_level;
  logic [5:0] pkt_type;
  int fails, comparisons, cycles, n;
  ////////////////////////////////////////////////////////////////////////
  ivf_regs dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .scl_run(scl_run), .scl_o(scl_o),
    .scl_oe(scl_oe), .tgt_setup_start(tgt_setup_start), .tgt_scl_release(tgt_scl_release),
    .remote_pin_value(remote_pin_value), .pin_in(pin_level), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_sampled(pin_sampled), .high_rate_video_mode(high_rate_video_mode),
    .pkt_valid(pkt_valid), .pkt_type(pkt_type), .frame_valid_in(frame_valid_in),
    .line_valid_in(line_valid_in), .pkt_pass(pkt_pass), .frame_valid_out(frame_valid_out),
    .line_valid_out(line_valid_out));
  ivf_far_side far (.ref_clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe), .scl_o(scl_o),
    .scl_oe(scl_oe), .ext_val(ext_val), .ext_en(ext_en), .pin_level(pin_level),
    .scl_level(scl_level));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic end_of_test();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_rng(input string nm, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi) begin
      fails++;
      $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    reg_addr = a;
    reg_wr_en = 1'b1;
    reg_wr_data = d;
    tick(1);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    reg_addr = a;
    tick(2);
    q = reg_rd_data;
  endtask
  task automatic scl_meas(input int hi_t, input int lo_t);
    int h, l;
    h = 0;
    l = 0;
    scl_run = 1'b1;
    while (scl_level !== 1'b0) tick(1);
    while (scl_level === 1'b0) begin
      l++;
      tick(1);
    end
    while (scl_level === 1'b1) begin
      h++;
      tick(1);
    end
    scl_run = 1'b0;
    cmp_rng("scl low", int'(lo_t * 3.80952) - 2, int'(lo_t * 3.80952) + 2, l);
    cmp_rng("scl high", int'(hi_t * 3.80952) - 2, int'(hi_t * 3.80952) + 2, h);
  endtask
  function automatic logic exp_pass(logic [7:0] c, logic [5:0] t, logic m);
    logic lg;
    lg = t[5] | t[4];
    return (c[IVF_BIT_ANY_LONG] & lg) | (c[IVF_BIT_MATCH_EN] & lg & (t == 6'h2A)) |
      (c[IVF_BIT_YUV_EN] & m & (t == IVF_DT_YUV_A || t == IVF_DT_YUV_B || t == IVF_DT_YUV_C));
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, reg_wr_en, scl_run, tgt_setup_start, pkt_valid, high_rate_video_mode} = '0;
    {reg_addr, reg_wr_data, remote_pin_value, ext_val, ext_en, pkt_type} = '0;
    {frame_valid_in, line_valid_in} = '0;
    tick(16);
    cmp("oe in reset", 8'h00, {4'h0, pin_oe});
    rst_b = 1'b1;
    scl_meas(132, 132);
    foreach (ROWS[i]) begin
      if (ROWS[i].w) wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, v);
      cmp("reg", ROWS[i].e, v);
    end
    remote_pin_value = 4'hA;
    tick(2);
    cmp("fwd pins", 8'hFA, {pin_oe, pin_o});
    wr(8'h0D, 8'h05);
    wr(8'h0E, 8'hF0);
    tick(2);
    cmp("local pins", 8'hF5, {pin_oe, pin_o});
    wr(8'h0E, 8'h3F);
    ext_val = 4'h8;
    ext_en = 4'hC;
    tick(4);
    cmp("drive", 8'h31, {pin_oe, pin_o & pin_oe});
    cmp("sampled", 8'h09, {4'h0, pin_sampled});
    wr(8'h0E, 8'h3A);
    tick(2);
    cmp("gated", 8'h08, {4'h0, pin_sampled});
    wr(8'h11, 8'h2A);
    foreach (CFGS[c]) begin
      wr(8'h10, CFGS[c]);
      foreach (TYPES[t]) begin
        for (int m = 0; m < 2; m++) begin
          tick(1);
          high_rate_video_mode = m[0];
          pkt_type = TYPES[t];
          pkt_valid = 1'b1;
          tick(1);
          pkt_valid = 1'b0;
          v = {7'h0, exp_pass(CFGS[c], TYPES[t], m[0])};
          cmp("pass", v, {7'h0, pkt_pass});
        end
      end
    end
    wr(8'h10, 8'h03);
    frame_valid_in = 1'b1;
    tick(2);
    cmp("fv lv", 8'h01, {6'h0, frame_valid_out, line_valid_out});
    wr(8'h0B, 8'h00);
    wr(8'h0C, 8'h01);
    scl_meas(5, 6);
    tgt_setup_start = 1'b1;
    tick(1);
    tgt_setup_start = 1'b0;
    n = 1;
    while (tgt_scl_release !== 1'b1) begin
      tick(1);
      n++;
    end
    cmp_rng("setup", 19, 26, n);
    end_of_test();
  end
endmodule
